// file: src/flow_out_pkg.sv
// Shared offsets, reset values and types of the flow output block
package flow_out_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] HOLD_OFS    = 8'h00;
  localparam logic [7:0] SUP_OFS     = 8'h04;
  localparam logic [7:0] CFG_OFS     = 8'h08;
  localparam logic [7:0] KFAC_OFS    = 8'h0c;
  localparam logic [7:0] WARNING_OFS = 8'h10;
  localparam logic [7:0] ERROR_OFS   = 8'h14;
  localparam logic [7:0] LOOP_OFS    = 8'h18;
  localparam logic [7:0] LOOP_STRIDE = 8'h08;
  localparam logic [7:0] SLOPE_ADD   = 8'h04;
  localparam logic [7:0] SWTHR_OFS   = 8'h28;
  localparam logic [7:0] TRIM_OFS    = 8'h30;
  localparam logic [7:0] CONF_OFS    = 8'h34;
  localparam logic [7:0] TRES_OFS    = 8'h38;
  localparam logic [7:0] TOT_OFS     = 8'h3c;
  localparam logic [7:0] TEST_OFS    = 8'h44;
  localparam logic [7:0] TMA_OFS     = 8'h48;
  localparam logic [7:0] SIM_OFS     = 8'h4c;
  localparam logic [7:0] CODE_OFS    = 8'h50;
  localparam logic [7:0] UNLK_OFS    = 8'h54;
  localparam logic [7:0] STAT_OFS    = 8'h58;
  localparam logic [7:0] MEAS_OFS    = 8'h5c;
  localparam logic [7:0] WORD_STRIDE = 8'h04;
  // Loop currents in microamps
  localparam logic [15:0] LOOP_MIN_UA   = 16'h0fa0;
  localparam logic [15:0] LOOP_MAX_UA   = 16'h4e20;
  localparam logic [15:0] LOOP_FAULT_UA = 16'h55f0;
  localparam logic [15:0] SPAN_UA       = 16'h3e80;
  localparam logic [15:0] DAC_MAX_UA    = 16'h5dc0;
  // Fixed point positions and reset values
  localparam logic [15:0] GAIN_ONE   = 16'h4000;
  localparam int          GAIN_FRAC  = 14;
  localparam int          SLOPE_FRAC = 16;
  localparam logic [15:0] KFAC_RST   = 16'h0001;
  localparam logic [15:0] CODE_RST   = 16'h0000;
  localparam int          CHANNELS   = 2;
  localparam int          MENU_CAL   = 0;
  localparam int          MENU_SUPV  = 1;
  localparam int          MENU_TEST  = 2;
  localparam int          HOLD_BIT   = 0;
  localparam int          SUP_BIT    = 0;

  typedef enum logic [1:0] {SW_HYST, SW_WINDOW, SW_PULSE, SW_WARNING} sw_mode_e;
  typedef enum logic [1:0] {PV_FLOW, PV_FREQ, PV_TOT1, PV_TOT2} pv_sel_e;
  typedef enum logic [1:0] {TRIM_NONE, TRIM_OFFSET, TRIM_SPAN} trim_mode_e;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } limits_s;

  typedef struct packed {
    logic [19:0]      spare;
    logic [1:0]       nc;
    logic [1:0][1:0]  sw_mode;
    logic [1:0]       fault_drive;
    logic [1:0][1:0]  pv_sel;
  } out_cfg_s;

  typedef struct packed {
    logic [15:0] meas;
    logic [12:0] spare;
    trim_mode_e  mode;
    logic        sel;
  } trim_s;

  typedef struct packed {
    logic [22:0] spare;
    pv_sel_e     sim_sel;
    logic        sim_en;
    logic [1:0]  sw_val;
    logic [1:0]  force_sw;
    logic [1:0]  force_loop;
  } test_s;

  typedef struct packed {
    logic [13:0] spare;
    logic [1:0]  menu;
    logic [15:0] code;
  } key_s;
endpackage : flow_out_pkg

// file: src/seq_divider.sv
// Restoring serial divider, one quotient bit per enabled clock
`timescale 1ns/1ps
`default_nettype none
module seq_divider #(
  parameter int W = 32
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quo
);
  localparam int CW = $clog2(W + 1);
  logic [W-1:0]  rem;
  logic [W-1:0]  den_q;
  logic [CW-1:0] cnt;
  wire  [W:0]    shifted = {rem, quo[W-1]};
  wire  [W:0]    trial   = shifted - {1'b0, den_q};

  // A zero divisor simply yields all ones; start is ignored while busy
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rem   <= '0;
      den_q <= '0;
      quo   <= '0;
      cnt   <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && !busy) begin
        quo   <= num;
        rem   <= '0;
        den_q <= den;
        cnt   <= CW'(W);
        busy  <= 1'b1;
      end else if (busy) begin
        rem  <= trial[W] ? shifted[W-1:0] : trial[W-1:0];
        quo  <= {quo[W-2:0], ~trial[W]};
        cnt  <= cnt - CW'(1);
        busy <= (cnt != CW'(1));
        done <= (cnt == CW'(1));
      end
    end
  end
endmodule : seq_divider
`default_nettype wire

// file: src/loop_scaler.sv
// Maps a process value onto a loop current and applies the trim correction
`timescale 1ns/1ps
`default_nettype none
module loop_scaler (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  input  wire logic [31:0]        pv,
  input  wire logic [31:0]        zero,
  input  wire logic signed [15:0] slope,
  input  wire logic               ovr,
  input  wire logic [15:0]        ovr_ua,
  input  wire logic signed [15:0] offs,
  input  wire logic [15:0]        gain,
  output logic [15:0]             ua
);
  wire signed [32:0] diff = $signed({1'b0, pv}) - $signed({1'b0, zero});
  wire signed [48:0] prod = diff * slope;
  wire signed [48:0] lo_s = $signed({33'h0, flow_out_pkg::LOOP_MIN_UA});
  wire signed [48:0] hi_s = $signed({33'h0, flow_out_pkg::LOOP_MAX_UA});
  wire signed [48:0] lin  = (prod >>> flow_out_pkg::SLOPE_FRAC) + lo_s;
  logic [15:0] ideal;

  // Linear part clamps to 4..20 mA; an inverted range uses a negative slope
  always_comb begin
    if (ovr) ideal = ovr_ua;
    else if (lin < lo_s) ideal = flow_out_pkg::LOOP_MIN_UA;
    else if (lin > hi_s) ideal = flow_out_pkg::LOOP_MAX_UA;
    else ideal = lin[15:0];
  end

  // Trim acts on every current, forced ones included, as the DAC sees it
  wire [31:0]        scaled = ideal * gain;
  wire signed [19:0] corr   =
    $signed({2'b00, scaled[31:flow_out_pkg::GAIN_FRAC]}) + 20'(offs);
  wire signed [19:0] top    = $signed({4'h0, flow_out_pkg::DAC_MAX_UA});

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) ua <= '0;
    else if (clk_en) begin
      if (corr < 0) ua <= '0;
      else if (corr > top) ua <= flow_out_pkg::DAC_MAX_UA;
      else ua <= corr[15:0];
    end
  end
endmodule : loop_scaler
`default_nettype wire

// file: src/flow_output_hold_monitor.sv
// Output hold, loop trim, totalizers and frequency supervision over APB
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Reset always comes up with hold cleared.
// - In hold each loop keeps the current of its last measured value.
// - In hold each switch output outside pulse mode keeps its state from hold entry.
// - A switch in pulse mode keeps pulsing during hold.
// - Only software clears hold, apart from reset.
// - A menu whose code is zero needs no unlock.
// - Confirmed totalizer reset clears it; a no choice leaves it alone.
// - Offset trim drives 4 mA, then corrects offset from the entry.
// - Span trim drives 20 mA, then corrects gain from the entry.
// - Trim entries are dropped; correction applies only on confirm.
// - Flow equals input frequency divided by the K-factor.
// - Supervision disabled means no frequency events at all.
// - Warning when frequency is above or below the warning limits.
// - Error when frequency is above or below the error limits.
// - Warning event can drive either or both switch outputs.
// - Error event can be routed to either or both loops.
// - An output under test ignores the measured value.
// - Loop test drives the confirmed entered current.
// - Switch test forces the confirmed on or off state.
// - Behaviour test substitutes a value; configured outputs follow it.
// - With fault drive selected, a supervision error drives 22 mA.
// - A device malfunction drives 22 mA on every loop not under test.
module flow_output_hold_monitor (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] freq_value,
  input  wire logic        freq_valid,
  input  wire logic        vol_tick,
  input  wire logic        vol_pulse,
  input  wire logic        device_fault,
  output logic [15:0]      current_loop_one,
  output logic [15:0]      current_loop_two,
  output logic             switch_output_one,
  output logic             switch_output_two
);
  localparam int N = flow_out_pkg::CHANNELS;

  // Software settings and block state
  logic                    hold;
  logic                    sup_en;
  flow_out_pkg::out_cfg_s  cfg;
  logic [15:0]             kfactor;
  flow_out_pkg::limits_s   warning_lim;
  flow_out_pkg::limits_s   error_lim;
  flow_out_pkg::trim_s     trim;
  flow_out_pkg::test_s     test;
  logic [31:0]             test_ma;
  logic [31:0]             sim_value;
  logic [15:0]             code [3];
  logic [2:0]              unlocked;
  logic [2:0]              granted;
  logic [31:0]             tot [N];
  logic [15:0]             freq_q;
  logic [15:0]             flow;
  logic                    warning_evt;
  logic                    error_evt;
  logic [15:0]             loop_ua [N];
  logic [N-1:0]            sw_pin;
  logic [31:0]             loop_rd [N];
  logic [31:0]             sw_rd [N];
  logic [N-1:0]            loop_map;
  logic [N-1:0]            tot_hit;
  logic [N-1:0]            sw_map;
  logic [31:0]             rd_fixed;
  logic                    div_busy;
  logic                    div_done;
  logic [31:0]             div_quo;

  // Address decode
  wire hit_hold = paddr == flow_out_pkg::HOLD_OFS;
  wire hit_sup  = paddr == flow_out_pkg::SUP_OFS;
  wire hit_cfg  = paddr == flow_out_pkg::CFG_OFS;
  wire hit_kfac = paddr == flow_out_pkg::KFAC_OFS;
  wire hit_wlim = paddr == flow_out_pkg::WARNING_OFS;
  wire hit_elim = paddr == flow_out_pkg::ERROR_OFS;
  wire hit_trim = paddr == flow_out_pkg::TRIM_OFS;
  wire hit_conf = paddr == flow_out_pkg::CONF_OFS;
  wire hit_tres = paddr == flow_out_pkg::TRES_OFS;
  wire hit_test = paddr == flow_out_pkg::TEST_OFS;
  wire hit_tma  = paddr == flow_out_pkg::TMA_OFS;
  wire hit_sim  = paddr == flow_out_pkg::SIM_OFS;
  wire hit_code = paddr == flow_out_pkg::CODE_OFS;
  wire hit_unlk = paddr == flow_out_pkg::UNLK_OFS;
  wire hit_stat = paddr == flow_out_pkg::STAT_OFS;
  wire hit_meas = paddr == flow_out_pkg::MEAS_OFS;

  // Menu gating: settings of a locked menu refuse writes with pslverr
  flow_out_pkg::key_s wkey;
  assign wkey = flow_out_pkg::key_s'(pwdata);
  wire [3:0] grant_ix = {1'b0, granted};
  wire cal_reg  = hit_hold | hit_kfac | hit_trim | hit_conf | hit_tres;
  wire supv_reg = hit_sup | hit_wlim | hit_elim;
  wire test_reg = hit_test | hit_tma | hit_sim;
  wire ro_reg   = hit_stat | hit_meas | (|tot_hit);
  wire key_bad  = (hit_code & ~grant_ix[wkey.menu]) |
                  ((hit_code | hit_unlk) & (&wkey.menu));
  wire locked   = (cal_reg & ~granted[flow_out_pkg::MENU_CAL]) |
                  (supv_reg & ~granted[flow_out_pkg::MENU_SUPV]) |
                  (test_reg & ~granted[flow_out_pkg::MENU_TEST]) | key_bad;
  wire mapped   = cal_reg | supv_reg | test_reg | ro_reg | hit_cfg |
                  hit_code | hit_unlk | (|loop_map) | (|sw_map);
  wire bad      = ~mapped | (pwrite & (ro_reg | locked));
  wire wr_ok    = clk_en & psel & penable & pwrite & ~bad;
  wire trim_go  = wr_ok & hit_conf & pwdata[0];
  wire [1:0] tot_clr = {2{wr_ok & hit_tres}} & pwdata[1:0];

  // Zero wait states; freezing the clock enable also stalls the bus
  assign pready  = clk_en;
  assign pslverr = psel & penable & bad;

  // Access is free when a menu code is still zero
  for (genvar m = 0; m < 3; m++) begin : g_menu
    assign granted[m] = (code[m] == flow_out_pkg::CODE_RST) | unlocked[m];
  end

  // Readback of the single registers
  always_comb begin
    case (paddr)
      flow_out_pkg::HOLD_OFS:    rd_fixed = {31'h0, hold};
      flow_out_pkg::SUP_OFS:     rd_fixed = {31'h0, sup_en};
      flow_out_pkg::CFG_OFS:     rd_fixed = cfg;
      flow_out_pkg::KFAC_OFS:    rd_fixed = {16'h0, kfactor};
      flow_out_pkg::WARNING_OFS: rd_fixed = warning_lim;
      flow_out_pkg::ERROR_OFS:   rd_fixed = error_lim;
      flow_out_pkg::TRIM_OFS:    rd_fixed = trim;
      flow_out_pkg::TEST_OFS:    rd_fixed = test;
      flow_out_pkg::TMA_OFS:     rd_fixed = test_ma;
      flow_out_pkg::SIM_OFS:     rd_fixed = sim_value;
      flow_out_pkg::UNLK_OFS:    rd_fixed = {29'h0, granted};
      flow_out_pkg::STAT_OFS:    rd_fixed = {24'h0, div_busy, granted,
                                   device_fault, error_evt, warning_evt, hold};
      flow_out_pkg::MEAS_OFS:    rd_fixed = {flow, freq_q};
      default:                   rd_fixed = 32'h0;
    endcase
  end

  wire [31:0] rdata_mux = rd_fixed | loop_rd[0] | loop_rd[1] |
                          sw_rd[0] | sw_rd[1];

  // Read data is captured in the setup cycle and stands through access
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) prdata <= 32'h0;
    else if (clk_en && psel && !penable) prdata <= rdata_mux;
  end

  // Software settings; codes are write only so they cannot be read back
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold        <= 1'b0;
      sup_en      <= 1'b0;
      cfg         <= '0;
      kfactor     <= flow_out_pkg::KFAC_RST;
      warning_lim <= '0;
      error_lim   <= '0;
      trim        <= '0;
      test        <= '0;
      test_ma     <= 32'h0;
      sim_value   <= 32'h0;
      code        <= '{default: flow_out_pkg::CODE_RST};
      unlocked    <= 3'h0;
    end else if (wr_ok) begin
      if (hit_hold) hold <= pwdata[flow_out_pkg::HOLD_BIT];
      if (hit_sup) sup_en <= pwdata[flow_out_pkg::SUP_BIT];
      if (hit_cfg) cfg <= flow_out_pkg::out_cfg_s'(pwdata);
      if (hit_kfac) kfactor <= pwdata[15:0];
      if (hit_wlim) warning_lim <= flow_out_pkg::limits_s'(pwdata);
      if (hit_elim) error_lim <= flow_out_pkg::limits_s'(pwdata);
      if (hit_trim) trim <= flow_out_pkg::trim_s'(pwdata);
      if (hit_conf) trim.meas <= 16'h0;
      if (hit_test) test <= flow_out_pkg::test_s'(pwdata);
      if (hit_tma) test_ma <= pwdata;
      if (hit_sim) sim_value <= pwdata;
      if (hit_code) code[wkey.menu] <= wkey.code;
      if (hit_unlk) unlocked[wkey.menu] <= wkey.code == code[wkey.menu];
    end
  end

  // Flow rate from frequency; a sample during a busy divide is skipped
  seq_divider #(
    .W (32)
  ) u_flow_div (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .start  (freq_valid),
    .num    ({8'h00, freq_value, 8'h00}),
    .den    ({16'h0, kfactor}),
    .busy   (div_busy),
    .done   (div_done),
    .quo    (div_quo)
  );

  // Frequency supervision, re-evaluated on each new sample
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      freq_q      <= 16'h0;
      flow        <= 16'h0;
      warning_evt <= 1'b0;
      error_evt   <= 1'b0;
    end else if (clk_en) begin
      if (freq_valid) freq_q <= freq_value;
      if (!sup_en) begin
        warning_evt <= 1'b0;
        error_evt   <= 1'b0;
      end else if (freq_valid) begin
        warning_evt <= (freq_value > warning_lim.hi) |
                       (freq_value < warning_lim.lo);
        error_evt   <= (freq_value > error_lim.hi) |
                       (freq_value < error_lim.lo);
      end
      if (div_done) flow <= (|div_quo[31:16]) ? 16'hffff : div_quo[15:0];
    end
  end

  // Per loop: source select, hold, override, trim and its totalizer
  for (genvar i = 0; i < N; i++) begin : g_loop
    flow_out_pkg::pv_sel_e sel;
    logic [31:0]           zero;
    logic signed [15:0]    slope;
    logic signed [15:0]    offs;
    logic [15:0]           gain;
    logic [31:0]           pv_meas;
    logic [31:0]           held_pv;
    logic                  ovr;
    logic [15:0]           ovr_ua;
    logic                  gdone;
    logic [31:0]           gquo;
    wire [7:0]  base      = flow_out_pkg::LOOP_OFS +
                            8'(i) * flow_out_pkg::LOOP_STRIDE;
    wire        hit_zero  = paddr == base;
    wire        hit_slope = paddr == base + flow_out_pkg::SLOPE_ADD;
    wire        hit_tot   = paddr == flow_out_pkg::TOT_OFS +
                            8'(i) * flow_out_pkg::WORD_STRIDE;
    wire        mine      = trim.sel == 1'(i);
    wire        trim_on   = mine & (trim.mode != flow_out_pkg::TRIM_NONE);
    wire        go_offs   = trim_go & mine &
                            (trim.mode == flow_out_pkg::TRIM_OFFSET);
    wire        go_span   = trim_go & mine &
                            (trim.mode == flow_out_pkg::TRIM_SPAN);
    wire [15:0] span_meas = trim.meas - flow_out_pkg::LOOP_MIN_UA;
    wire [31:0] gnum      = {16'h0, gain} * {16'h0, flow_out_pkg::SPAN_UA};
    wire        sim_hit   = test.sim_en & (test.sim_sel == sel);
    wire [31:0] pv_live   = sim_hit ? sim_value : pv_meas;
    wire [31:0] pv_use    = hold ? held_pv : pv_live;

    assign sel         = flow_out_pkg::pv_sel_e'(cfg.pv_sel[i]);
    assign loop_map[i] = hit_zero | hit_slope | hit_tot;
    assign tot_hit[i]  = hit_tot;
    assign loop_rd[i]  = hit_zero ? zero :
                         hit_slope ? {{16{slope[15]}}, slope} :
                         hit_tot ? tot[i] : 32'h0;

    always_comb begin
      case (sel)
        flow_out_pkg::PV_FLOW: pv_meas = {16'h0, flow};
        flow_out_pkg::PV_FREQ: pv_meas = {16'h0, freq_q};
        flow_out_pkg::PV_TOT1: pv_meas = tot[0];
        default:               pv_meas = tot[1];
      endcase
    end

    // Test beats everything, then faults, then the trim nominal
    always_comb begin
      ovr = 1'b1;
      if (test.force_loop[i]) ovr_ua = test_ma[16*i +: 16];
      else if (device_fault) ovr_ua = flow_out_pkg::LOOP_FAULT_UA;
      else if (cfg.fault_drive[i] && error_evt)
        ovr_ua = flow_out_pkg::LOOP_FAULT_UA;
      else if (trim_on)
        ovr_ua = (trim.mode == flow_out_pkg::TRIM_SPAN) ?
                 flow_out_pkg::LOOP_MAX_UA :
                 flow_out_pkg::LOOP_MIN_UA;
      else begin
        ovr    = 1'b0;
        ovr_ua = flow_out_pkg::LOOP_MIN_UA;
      end
    end

    // Scaling, trim and held value; totalizer clear beats a tick
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        zero    <= 32'h0;
        slope   <= 16'sh0;
        offs    <= 16'sh0;
        gain    <= flow_out_pkg::GAIN_ONE;
        held_pv <= 32'h0;
        tot[i]  <= 32'h0;
      end else if (clk_en) begin
        if (wr_ok && hit_zero) zero <= pwdata;
        if (wr_ok && hit_slope) slope <= pwdata[15:0];
        if (!hold) held_pv <= pv_live;
        if (go_offs)
          offs <= offs + $signed(flow_out_pkg::LOOP_MIN_UA - trim.meas);
        if (gdone)
          gain <= (|gquo[31:16]) ? 16'hffff : gquo[15:0];
        if (tot_clr[i]) tot[i] <= 32'h0;
        else if (vol_tick) tot[i] <= tot[i] + 32'h1;
      end
    end

    seq_divider #(
      .W (32)
    ) u_gain_div (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .clk_en (clk_en),
      .start  (go_span),
      .num    (gnum),
      .den    ({16'h0, span_meas}),
      .busy   (),
      .done   (gdone),
      .quo    (gquo)
    );

    loop_scaler u_scaler (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .clk_en (clk_en),
      .pv     (pv_use),
      .zero   (zero),
      .slope  (slope),
      .ovr    (ovr),
      .ovr_ua (ovr_ua),
      .offs   (offs),
      .gain   (gain),
      .ua     (loop_ua[i])
    );
  end

  // Per switch: threshold modes, pulse pass-through and warning route
  for (genvar j = 0; j < N; j++) begin : g_sw
    flow_out_pkg::sw_mode_e mode;
    flow_out_pkg::limits_s  thr;
    logic                   st;
    logic                   next_st;
    wire        hit_thr = paddr == flow_out_pkg::SWTHR_OFS +
                          8'(j) * flow_out_pkg::WORD_STRIDE;
    wire        sim_flw = test.sim_en & (test.sim_sel == flow_out_pkg::PV_FLOW);
    wire [15:0] v       = sim_flw ? sim_value[15:0] : flow;

    assign mode      = flow_out_pkg::sw_mode_e'(cfg.sw_mode[j]);
    assign sw_map[j] = hit_thr;
    assign sw_rd[j]  = hit_thr ? thr : 32'h0;

    always_comb begin
      case (mode)
        flow_out_pkg::SW_HYST:   next_st = (v >= thr.hi) | (st & (v > thr.lo));
        flow_out_pkg::SW_WINDOW: next_st = (v >= thr.lo) & (v <= thr.hi);
        flow_out_pkg::SW_PULSE:  next_st = vol_pulse;
        default:                 next_st = warning_evt;
      endcase
    end

    // Pin is registered so a forced test state never glitches
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        thr       <= '0;
        st        <= 1'b0;
        sw_pin[j] <= 1'b0;
      end else if (clk_en) begin
        if (wr_ok && hit_thr) thr <= flow_out_pkg::limits_s'(pwdata);
        if (!hold || mode == flow_out_pkg::SW_PULSE) st <= next_st;
        sw_pin[j] <= test.force_sw[j] ? test.sw_val[j] :
                     st ^ cfg.nc[j];
      end
    end
  end

  // Output pins
  assign current_loop_one  = loop_ua[0];
  assign current_loop_two  = loop_ua[1];
  assign switch_output_one = sw_pin[0];
  assign switch_output_two = sw_pin[1];
endmodule : flow_output_hold_monitor
`default_nettype wire

// file: verification/flow_out_chk.sv
// Port checks of the flow output block
`timescale 1ns/1ps
`default_nettype none
module flow_out_chk (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] current_loop_one
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire acc = psel && penable;
  // Loop must land on the 4 mA point soon after release
  sequence s_min;
    current_loop_one == flow_out_pkg::LOOP_MIN_UA;
  endsequence
  a_reset_min: assert property ($rose(rst_b) |-> ##[1:4] s_min)
    else $error("loop not at 4 mA after reset");
  a_ready_en: assert property (pready == clk_en)
    else $error("pready differs from clk_en");
  a_err_access: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  a_ro_refused: assert property
    (acc && pwrite && paddr == flow_out_pkg::STAT_OFS |-> pslverr)
    else $error("status write accepted");
  a_unmapped_err: assert property (acc && paddr > 8'h5f |-> pslverr)
    else $error("unmapped address accepted");
  a_read_ok: assert property
    (acc && !pwrite && paddr <= 8'h5c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped read refused");
  a_rdata_stands: assert property (acc |=> $stable(prdata))
    else $error("read data moved after access");
  a_loop_ceil: assert property
    (current_loop_one <= flow_out_pkg::DAC_MAX_UA)
    else $error("loop above ceiling");
  a_freeze_en: assert property (!clk_en |=> $stable(current_loop_one))
    else $error("loop moved while clock enable low");
endmodule : flow_out_chk
bind flow_output_hold_monitor flow_out_chk chk (.mclk(mclk),
  .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .current_loop_one(current_loop_one));
`default_nettype wire

// file: verification/loop_reader.sv
// Control system that latches the loop current and switch pins
`timescale 1ns/1ps
`default_nettype none
module loop_reader (
  input  wire logic        mclk,
  input  wire logic [15:0] loop_one,
  input  wire logic [1:0]  sw,
  output logic [15:0]      seen_one,
  output logic [1:0]       seen_sw
);
  // One cycle late, like a sampling input card
  always_ff @(posedge mclk) begin
    seen_one <= loop_one;
    seen_sw <= sw;
  end
endmodule : loop_reader
`default_nettype wire

// file: verification/tb_flow_output_hold_monitor.sv
// Self-checking bench of the flow output block
`timescale 1ns/1ps
`default_nettype none
module tb_flow_output_hold_monitor;
  logic mclk = 0, rst_b = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic fv = 0, tick = 0, flt = 0, pready, pslverr, er;
  logic [7:0] paddr = 0;
  logic [15:0] fval = 0, s1, c2;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] sw, ss;
  int errors = 0, check_count = 0, cyc = 0;
  flow_output_hold_monitor uut (.mclk(mclk), .rst_b(rst_b),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .freq_value(fval), .freq_valid(fv),
    .vol_tick(tick), .vol_pulse(tick), .device_fault(flt),
    .current_loop_one(), .current_loop_two(c2),
    .switch_output_one(sw[0]), .switch_output_two(sw[1]));
  loop_reader pcs (.mclk(mclk), .loop_one(uut.current_loop_one),
    .sw(sw), .seen_one(s1), .seen_sw(ss));
  always #25 mclk = ~mclk;
  task conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Hang guard
  always @(posedge mclk) if (++cyc > 20000) begin errors++; conclude(); end
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task sample(input logic [15:0] f);
    @(posedge mclk);
    {fval, fv} <= {f, 1'b1};
    @(posedge mclk);
    fv <= 1'b0;
    repeat (40) @(posedge mclk);
  endtask : sample
  task t_hold;
    apb(1, flow_out_pkg::KFAC_OFS, 32'h0100);
    apb(1, flow_out_pkg::CFG_OFS, 32'h0001);
    apb(1, flow_out_pkg::LOOP_OFS + flow_out_pkg::SLOPE_ADD, 32'h7fff);
    sample(16'h03e8);
    chk(s1, 16'h1193);
    apb(0, flow_out_pkg::MEAS_OFS, 0);
    chk(rd, 32'h03e803e8);
    apb(1, flow_out_pkg::HOLD_OFS, 32'h1);
    sample(16'h07d0);
    chk(s1, 16'h1193);
    apb(0, flow_out_pkg::HOLD_OFS, 0);
    chk(rd[0], 1'b1);
    apb(1, flow_out_pkg::HOLD_OFS, 32'h0);
    repeat (4) @(posedge mclk);
    chk(s1, 16'h1387);
  endtask : t_hold
  task t_supv;
    apb(1, flow_out_pkg::WARNING_OFS, 32'h0bb801f4);
    apb(1, flow_out_pkg::ERROR_OFS, 32'h13880064);
    apb(1, flow_out_pkg::CFG_OFS, 32'h00d1);
    apb(1, flow_out_pkg::SUP_OFS, 32'h1);
    sample(16'h0fa0);
    apb(0, flow_out_pkg::STAT_OFS, 0);
    chk(rd[2:1], 2'b01);
    chk(ss[0], 1'b1);
    sample(16'h1770);
    apb(0, flow_out_pkg::STAT_OFS, 0);
    chk(rd[2:1], 2'b11);
    chk(s1, flow_out_pkg::LOOP_FAULT_UA);
    chk(c2, flow_out_pkg::LOOP_MIN_UA);
    sample(16'h03e8);
    chk(s1, 16'h1193);
    apb(1, flow_out_pkg::SUP_OFS, 32'h0);
    sample(16'h0064);
    apb(0, flow_out_pkg::STAT_OFS, 0);
    chk(rd[2:1], 2'b00);
  endtask : t_supv
  task t_misc;
    repeat (3) begin
      @(posedge mclk) tick <= 1'b1;
      @(posedge mclk) tick <= 1'b0;
    end
    apb(1, flow_out_pkg::TRES_OFS, 32'h1);
    apb(0, flow_out_pkg::TOT_OFS, 0);
    chk(rd, 32'h0);
    apb(0, flow_out_pkg::TOT_OFS + flow_out_pkg::WORD_STRIDE, 0);
    chk(rd, 32'h3);
    flt <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(s1, flow_out_pkg::LOOP_FAULT_UA);
    chk(c2, flow_out_pkg::LOOP_FAULT_UA);
    flt <= 1'b0;
    apb(1, flow_out_pkg::TMA_OFS, 32'h1f402ee0);
    apb(1, flow_out_pkg::TEST_OFS, 32'h15);
    repeat (4) @(posedge mclk);
    chk(s1, 16'h2ee0);
    chk(ss[0], 1'b1);
    clk_en <= 1'b0;
    repeat (3) @(posedge mclk);
    clk_en <= 1'b1;
    apb(1, flow_out_pkg::STAT_OFS, 0);
    chk(er, 1'b1);
    apb(0, 8'h80, 0);
    chk(er, 1'b1);
  endtask : t_misc
  task t_reset;
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(s1, flow_out_pkg::LOOP_MIN_UA);
    apb(0, flow_out_pkg::STAT_OFS, 0);
    chk(rd[7:0], 8'h70);
  endtask : t_reset
  initial begin
    repeat (8) @(posedge mclk);
    t_reset();
    t_hold();
    t_supv();
    t_misc();
    apb(1, flow_out_pkg::HOLD_OFS, 1);
    rst_b <= 1'b0;
    @(posedge mclk);
    t_reset();
    conclude();
  end
endmodule : tb_flow_output_hold_monitor
`default_nettype wire
